// File: core/gpcb_bank.sv
// Purpose: Configuration bank and pad logic for seven general purpose pins
// Assumes: main_por_rst and hard_rst are synchronous to clk_sys; pins are asynchronous
// Notes: srst acts as the standby power-on reset and loads every register except the pin synchronisers and the previous lock level
// How it works
// - Config bit 0 chooses direction, one is input, zero is output.
// - Config bit 1 inverts the value between pin and logic.
// - Config bit 7 selects open-drain driver, else push-pull.
// - Power pin bit 2 routes power event output; bits 6:3 reserved.
// - Power event drives active low when output and not inverted.
// - Lockable pin field 11 gives either-edge interrupt, 00 gives GPIO.
// - Lockable field 01 selects disable control; pin then plain non-inverted input.
// - Once field holds 01, writes to it are ignored until a reset.
// - Any of the three resets clears the lockable pin field.
// - Under disable control, pin high makes disable register read-only.
// - Serial pins code 01 route port 2 modem and data signals.
// - Bits 6:4 of two-bit-field registers are reserved.
// - Standby reset loads 0x01, transmit pin register loads 0x00.
// - Unassigned locations read as zero.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module gpcb_bank
    import gpcb_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic main_por_rst,
    input wire logic hard_rst,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe_n,
    // Power management
    input wire logic pme_assert,
    // Device disable
    output logic device_disable_lock_ctrl,
    output logic [7:0] device_disable_value,
    // Serial port 2
    output logic port2_ring_indicate_n,
    output logic port2_carrier_detect_n,
    output logic port2_receive_line,
    input wire logic port2_transmit_line,
    output logic port2_data_set_ready_n,
    // Interrupt
    output logic edge_event3,
    output logic irq
);

    function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[ADDR_W-1:10] != '0 || addr[1:0] != 2'h0) begin
            return SLOT_NONE;
        end
        if (idx >= IDX_PWR && idx <= IDX_DSR) begin
            return 4'(idx - IDX_PWR);
        end
        case (idx)
            IDX_DATA: return SLOT_DATA;
            IDX_ISTAT: return SLOT_ISTAT;
            IDX_IMASK: return SLOT_IMASK;
            IDX_DDIS: return SLOT_DDIS;
            default: return SLOT_NONE;
        endcase
    endfunction

    // True when a two-bit function field selects its routed signal
    function automatic logic fn_is_alt(input logic [7:0] cfg);
        return cfg[FN_HI:FN_LO] == FN_ALT;
    endfunction

    logic [NPIN-1:0][7:0] cfg_r;
    logic [7:0] data_r;
    logic [7:0] ddis_r;
    logic [IRQ_W-1:0] istat_r;
    logic [IRQ_W-1:0] imask_r;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic lock_prev_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic edge_r;

    // Write channel
    wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    wire [3:0] wr_slot = slot_of(s_axi_awaddr);
    wire wr_lane = wr_fire & s_axi_wstrb[0];
    wire [7:0] wr_byte = s_axi_wdata[7:0];
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = RESP_OKAY;

    // Read channel
    wire rd_fire = s_axi_arvalid & ~rvalid_r;
    wire [3:0] rd_slot = slot_of(s_axi_araddr);
    assign s_axi_arready = rd_fire;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = RESP_OKAY;

    // Per-pin decode
    wire [NPIN-1:0] dir_in;
    wire [NPIN-1:0] inv;
    wire [NPIN-1:0] od;
    wire [NPIN-1:0] in_val;
    wire [NPIN-1:0] src;
    wire [NPIN-1:0] drive_val;
    wire [NPIN-1:0] drive_en;
    wire [1:0] lock_fn = cfg_r[PIN_LOCK][FN_HI:FN_LO];
    wire locked = (lock_fn == FN_ALT);
    wire edge_mode = (lock_fn == FN_EDGE);
    wire pwr_alt = cfg_r[PIN_PWR][ALT_BIT];
    wire txd_alt = fn_is_alt(cfg_r[PIN_TXD]);
    wire power_event_out_n = ~pme_assert;
    wire lock_pin_raw = sync2_r[PIN_LOCK];
    wire ddis_writable = ~locked | ~lock_pin_raw;
    wire ddis_try = wr_lane && wr_slot == SLOT_DDIS;
    wire [7:0] cfg_wmask = (wr_slot == 4'(PIN_PWR)) ? WMASK_PWR : WMASK_FN;
    wire [7:0] cfg_wval = wr_byte & cfg_wmask;
    wire [IRQ_W-1:0] ev;
    wire [7:0] data_rd;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            assign dir_in[gi] = cfg_r[gi][DIR_BIT];
            assign od[gi] = cfg_r[gi][OD_BIT];
            if (gi == PIN_LOCK) begin : g_lock
                assign inv[gi] = cfg_r[gi][INV_BIT] & ~locked;
                assign drive_en[gi] = ~dir_in[gi] & ~locked & ~edge_mode;
            end else begin : g_plain
                assign inv[gi] = cfg_r[gi][INV_BIT];
                assign drive_en[gi] = ~dir_in[gi];
            end
            assign in_val[gi] = sync2_r[gi] ^ inv[gi];
            assign drive_val[gi] = src[gi] ^ inv[gi];
            assign data_rd[gi] = dir_in[gi] ? in_val[gi] : data_r[gi];
        end
    endgenerate
    assign data_rd[7] = 1'b0;

    // Output sources before inversion
    assign src[PIN_PWR] = pwr_alt ? power_event_out_n : data_r[PIN_PWR];
    assign src[PIN_LOCK] = data_r[PIN_LOCK];
    assign src[PIN_RI] = data_r[PIN_RI];
    assign src[PIN_DCD] = data_r[PIN_DCD];
    assign src[PIN_RXD] = data_r[PIN_RXD];
    assign src[PIN_TXD] = txd_alt ? port2_transmit_line : data_r[PIN_TXD];
    assign src[PIN_DSR] = data_r[PIN_DSR];

    // Interrupt events
    // Raw level, so a polarity write cannot fake an edge
    wire edge_hit = edge_mode & (lock_pin_raw != lock_prev_r);
    assign ev[IST_EDGE] = edge_hit;
    assign ev[IST_DDIS_BLOCK] = ddis_try & ~ddis_writable;
    wire [IRQ_W-1:0] ist_clr = (wr_lane && wr_slot == SLOT_ISTAT) ? wr_byte[IRQ_W-1:0] :
        IRQ_RST;

    // Read mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (rd_slot < 4'(NPIN)) begin
            rd_byte = cfg_r[rd_slot[2:0]];
        end else begin
            case (rd_slot)
                SLOT_DATA: rd_byte = data_rd;
                SLOT_ISTAT: rd_byte = {{(8 - IRQ_W){1'b0}}, istat_r};
                SLOT_IMASK: rd_byte = {{(8 - IRQ_W){1'b0}}, imask_r};
                SLOT_DDIS: rd_byte = ddis_r;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Pin input synchroniser
    always_ff @(posedge clk_sys) begin
        sync1_r <= pin_in;
        sync2_r <= sync1_r;
    end

    // Previous lockable pin level for edge detection
    always_ff @(posedge clk_sys) begin
        lock_prev_r <= lock_pin_raw;
    end

    // Configuration next value; main and hard reset touch two registers only
    wire soft_rst = main_por_rst | hard_rst;
    logic [NPIN-1:0][7:0] cfg_nxt;
    always_comb begin
        cfg_nxt = cfg_r;
        if (soft_rst) begin
            cfg_nxt[PIN_LOCK][FN_HI:FN_LO] = FN_GPIO;
            cfg_nxt[PIN_TXD] = CFG_TXD_RST;
        end else if (wr_lane && wr_slot < 4'(NPIN)) begin
            cfg_nxt[wr_slot[2:0]] = cfg_wval;
            if (wr_slot == 4'(PIN_LOCK) && locked) begin
                cfg_nxt[PIN_LOCK][FN_HI:FN_LO] = FN_ALT;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NPIN; i++) begin
                cfg_r[i] <= CFG_RST;
            end
            cfg_r[PIN_TXD] <= CFG_TXD_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // Data, device disable and interrupt next values
    wire data_we = wr_lane && wr_slot == SLOT_DATA;
    wire ddis_we = ddis_try & ddis_writable;
    wire imask_we = wr_lane && wr_slot == SLOT_IMASK;
    wire [7:0] data_nxt = data_we ? {1'b0, wr_byte[NPIN-1:0]} : data_r;
    wire [7:0] ddis_nxt = ddis_we ? wr_byte : ddis_r;
    wire [IRQ_W-1:0] imask_nxt = imask_we ? wr_byte[IRQ_W-1:0] : imask_r;
    // Set beats clear when an event meets a write of one
    wire [IRQ_W-1:0] istat_nxt = (istat_r & ~ist_clr) | ev;

    // Data and device disable registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_r <= DATA_RST;
            ddis_r <= DDIS_RST;
        end else begin
            data_r <= data_nxt;
            ddis_r <= ddis_nxt;
        end
    end

    // Interrupt status and mask registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            istat_r <= IRQ_RST;
            imask_r <= IRQ_RST;
        end else begin
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Response next values, held until the master takes them
    wire bvalid_nxt = wr_fire | (bvalid_r & ~s_axi_bready);
    wire rvalid_nxt = rd_fire | (rvalid_r & ~s_axi_rready);
    wire [31:0] rdata_nxt = rd_fire ? {24'h00_0000, rd_byte} : rdata_r;

    // Write response register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bvalid_r <= 1'b0;
        end else begin
            bvalid_r <= bvalid_nxt;
        end
    end

    // Read response registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Pad drive next values
    logic [NPIN-1:0] pin_out_r;
    logic [NPIN-1:0] pin_oe_n_r;
    wire [NPIN-1:0] pin_out_nxt;
    wire [NPIN-1:0] pin_oe_n_nxt;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pad
            // Open drain only ever pulls low
            assign pin_out_nxt[gi] = od[gi] ? 1'b0 : drive_val[gi];
            assign pin_oe_n_nxt[gi] = od[gi] ? ~(drive_en[gi] & ~drive_val[gi]) :
                ~drive_en[gi];
        end
    endgenerate

    // Pad registers, undriven after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    // Serial port 2 inputs, idle high unless routed
    logic [3:0] port2_in_r;
    wire [3:0] port2_in_nxt;
    assign port2_in_nxt[0] = fn_is_alt(cfg_r[PIN_RI]) ? in_val[PIN_RI] : 1'b1;
    assign port2_in_nxt[1] = fn_is_alt(cfg_r[PIN_DCD]) ? in_val[PIN_DCD] : 1'b1;
    assign port2_in_nxt[2] = fn_is_alt(cfg_r[PIN_RXD]) ? in_val[PIN_RXD] : 1'b1;
    assign port2_in_nxt[3] = fn_is_alt(cfg_r[PIN_DSR]) ? in_val[PIN_DSR] : 1'b1;

    // Serial port 2 input registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            port2_in_r <= 4'hF;
        end else begin
            port2_in_r <= port2_in_nxt;
        end
    end

    // Lock state and device disable copies
    logic lock_ctrl_r;
    logic [7:0] ddis_out_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lock_ctrl_r <= 1'b0;
            ddis_out_r <= DDIS_RST;
        end else begin
            lock_ctrl_r <= locked;
            ddis_out_r <= ddis_r;
        end
    end

    // Edge pulse and interrupt level
    logic irq_r;
    wire irq_nxt = |(istat_r & imask_r);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            edge_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            edge_r <= edge_hit;
            irq_r <= irq_nxt;
        end
    end

    // Output ports
    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign device_disable_lock_ctrl = lock_ctrl_r;
    assign device_disable_value = ddis_out_r;
    assign port2_ring_indicate_n = port2_in_r[0];
    assign port2_carrier_detect_n = port2_in_r[1];
    assign port2_receive_line = port2_in_r[2];
    assign port2_data_set_ready_n = port2_in_r[3];
    assign edge_event3 = edge_r;
    assign irq = irq_r;

endmodule
`default_nettype wire

// File: core/gpcb_pkg.sv
// Purpose: Constants for the GPIO pin configuration bank
// Assumes: Register index times four is the AXI4-Lite byte address
// Notes: Printed offsets are register indices, not byte addresses
package gpcb_pkg;
    // Geometry
    localparam int NPIN = 7;
    localparam int ADDR_W = 12;
    localparam int IRQ_W = 2;

    // Register indices
    localparam logic [7:0] IDX_PWR = 8'h3D;
    localparam logic [7:0] IDX_LOCK = 8'h3E;
    localparam logic [7:0] IDX_RI = 8'h3F;
    localparam logic [7:0] IDX_DCD = 8'h40;
    localparam logic [7:0] IDX_RXD = 8'h41;
    localparam logic [7:0] IDX_TXD = 8'h42;
    localparam logic [7:0] IDX_DSR = 8'h43;
    localparam logic [7:0] IDX_DATA = 8'h50;
    localparam logic [7:0] IDX_ISTAT = 8'h51;
    localparam logic [7:0] IDX_IMASK = 8'h52;
    localparam logic [7:0] IDX_DDIS = 8'h53;

    // Decoded register slots
    localparam logic [3:0] SLOT_DATA = 4'h7;
    localparam logic [3:0] SLOT_ISTAT = 4'h8;
    localparam logic [3:0] SLOT_IMASK = 4'h9;
    localparam logic [3:0] SLOT_DDIS = 4'hA;
    localparam logic [3:0] SLOT_NONE = 4'hF;

    // Pin positions
    localparam int PIN_PWR = 0;
    localparam int PIN_LOCK = 1;
    localparam int PIN_RI = 2;
    localparam int PIN_DCD = 3;
    localparam int PIN_RXD = 4;
    localparam int PIN_TXD = 5;
    localparam int PIN_DSR = 6;

    // Field positions
    localparam int DIR_BIT = 0;
    localparam int INV_BIT = 1;
    localparam int ALT_BIT = 2;
    localparam int FN_LO = 2;
    localparam int FN_HI = 3;
    localparam int OD_BIT = 7;

    // Function codes
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_ALT = 2'h1;
    localparam logic [1:0] FN_EDGE = 2'h3;

    // Reset values and writable masks
    localparam logic [7:0] CFG_RST = 8'h01;
    localparam logic [7:0] CFG_TXD_RST = 8'h00;
    localparam logic [7:0] WMASK_PWR = 8'h87;
    localparam logic [7:0] WMASK_FN = 8'h8F;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DDIS_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // Interrupt status bits
    localparam int IST_EDGE = 0;
    localparam int IST_DDIS_BLOCK = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// File: tb/gpcb_pad_model.sv
// Purpose: Board side of the seven pads
// Assumes: An undriven pad settles to the level the bench sets
// Notes: Open drain high is a release, so the board level shows
`timescale 1ns/1ps
`default_nettype none
module gpcb_pad_model
    import gpcb_pkg::*;
(
    // Pads
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe_n,
    input wire logic [NPIN-1:0] ext,
    output logic [NPIN-1:0] pin_in
);
    // Driven pads follow the device, released ones the board
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule
`default_nettype wire

// File: tb/gpcb_bank_checker.sv
// Purpose: Port level checks for the pin configuration bank
// Assumes: srst returns the registers to their reset values
// Notes: Bound to gpcb_bank after the module
`timescale 1ns/1ps
`default_nettype none
module gpcb_bank_checker
    import gpcb_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic main_por_rst,
    input wire logic hard_rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Pads and events
    input wire logic [NPIN-1:0] pin_in,
    input wire logic [NPIN-1:0] pin_oe_n,
    input wire logic device_disable_lock_ctrl,
    input wire logic edge_event3,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    aw_to_bvalid_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write taken without response");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    ar_to_rvalid_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read taken without data");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    lock_input_a: assert property (device_disable_lock_ctrl [*2] |-> pin_oe_n[PIN_LOCK])
        else $error("locked pin is driven");
    lock_sticky_a: assert property (device_disable_lock_ctrl && !main_por_rst && !hard_rst
        && !$past(main_por_rst) && !$past(hard_rst) |=> device_disable_lock_ctrl)
        else $error("lock released without reset");
    lock_clear_a: assert property (main_por_rst || hard_rst |-> ##[1:2] !device_disable_lock_ctrl)
        else $error("lock survives reset");
    edge_cause_a: assert property (edge_event3 |->
        $past(pin_in[PIN_LOCK], 3) != $past(pin_in[PIN_LOCK], 4))
        else $error("edge event without pin change");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(device_disable_lock_ctrl));
    cover property (edge_event3);
    cover property (irq);
endmodule
bind gpcb_bank gpcb_bank_checker u_chk (.clk_sys, .srst, .main_por_rst, .hard_rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .pin_in, .pin_oe_n,
    .device_disable_lock_ctrl, .edge_event3, .irq);
`default_nettype wire

// File: tb/gpio_pin_config_bank_bench.sv
// Purpose: Self-checking bench for the pin configuration bank
// Assumes: Byte address is register index times four
// Notes: Waits on handshakes are bounded and end the run when spent
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config_bank_bench
    import gpcb_pkg::*;
;
    logic clk_sys = '0, srst = '1, main_por_rst = '0, hard_rst = '0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, pme_assert = '0, port2_transmit_line = '1;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [NPIN-1:0] ext = '1, pin_in, pin_out, pin_oe_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic device_disable_lock_ctrl, port2_ring_indicate_n, port2_carrier_detect_n;
    logic port2_receive_line, port2_data_set_ready_n, edge_event3;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] device_disable_value;
    int num_errors = 0, compares = 0;

    gpcb_bank u_dut (.clk_sys, .srst, .main_por_rst, .hard_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
        .pme_assert, .device_disable_lock_ctrl, .device_disable_value, .port2_ring_indicate_n,
        .port2_carrier_detect_n, .port2_receive_line, .port2_transmit_line,
        .port2_data_set_ready_n, .edge_event3, .irq);
    gpcb_pad_model u_pad (.pin_out, .pin_oe_n, .ext, .pin_in);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] cfg_exp(input int r, input logic [7:0] d);
        return d & (r == PIN_PWR ? WMASK_PWR : WMASK_FN);
    endfunction

    task automatic close_out();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Bounded wait on one handshake signal, sampled after the edge settles
    task automatic hs(input int k);
        int n;
        n = 0;
        while (!(k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid :
                 k == 2 ? s_axi_arready : s_axi_rvalid)) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 50) begin
                num_errors++;
                close_out();
            end
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        #1;
        hs(0);
        @(posedge clk_sys);
        s_axi_awvalid <= '0;
        s_axi_wvalid <= '0;
        #1;
        hs(1);
        chk(s_axi_bresp, RESP_OKAY);
        @(posedge clk_sys);
        s_axi_bready <= '0;
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] d);
        @(posedge clk_sys);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        #1;
        hs(2);
        @(posedge clk_sys);
        s_axi_arvalid <= '0;
        #1;
        hs(3);
        chk(s_axi_rdata[31:8], 24'h0);
        chk(s_axi_rresp, RESP_OKAY);
        d = s_axi_rdata[7:0];
        @(posedge clk_sys);
        s_axi_rready <= '0;
    endtask

    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] d;
        rd(i, d);
        chk(d, e);
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] dd;
        int r;
        void'($urandom(32'h79BDEF66));
        tk(20);
        srst <= '0;
        for (r = 0; r < NPIN; r++) begin
            rc(8'(IDX_PWR + r), r == PIN_TXD ? CFG_TXD_RST : CFG_RST);
        end
        wr(8'h3C, 8'hFF);
        rc(8'h3C, 8'h00);
        for (int k = 0; k < 24; k++) begin
            r = (k % 7 == PIN_LOCK) ? PIN_PWR : k % 7;
            d = 8'($urandom);
            ext <= 7'($urandom);
            pme_assert <= 1'($urandom);
            port2_transmit_line <= 1'($urandom);
            wr(8'(IDX_PWR + r), d);
            rc(8'(IDX_PWR + r), cfg_exp(r, d));
        end
        ext <= '1;
        wr(IDX_RI, 8'h00);
        wr(IDX_DATA, 8'h04);
        tk(3);
        chk({pin_oe_n[PIN_RI], pin_out[PIN_RI]}, 2'h1);
        wr(IDX_RI, 8'h02);
        tk(3);
        chk({pin_oe_n[PIN_RI], pin_out[PIN_RI]}, 2'h0);
        wr(IDX_RI, 8'h80);
        tk(3);
        chk(pin_oe_n[PIN_RI], 1'h1);
        wr(IDX_DATA, 8'h00);
        tk(3);
        chk({pin_oe_n[PIN_RI], pin_out[PIN_RI]}, 2'h0);
        wr(IDX_DCD, 8'h01);
        tk(4);
        rd(IDX_DATA, d);
        chk(d[PIN_DCD], 1'h1);
        wr(IDX_DCD, 8'h03);
        tk(4);
        rd(IDX_DATA, d);
        chk(d[PIN_DCD], 1'h0);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_PWR, m[1] ? 8'h84 : 8'h04);
            pme_assert <= m[0];
            tk(3);
            chk(pin_in[PIN_PWR], !m[0]);
        end
        for (int c = 0; c < 4; c++) begin
            for (r = PIN_RI; r <= PIN_DSR; r++) begin
                wr(8'(IDX_PWR + r), r == PIN_TXD ? {c[1:0], 2'h0} : {c[1:0], 2'h1});
            end
            ext <= 7'($urandom);
            port2_transmit_line <= 1'($urandom);
            tk(4);
            chk({port2_ring_indicate_n, port2_carrier_detect_n, port2_receive_line,
                port2_data_set_ready_n}, c == 1 ? {ext[2], ext[3], ext[4], ext[6]} : 4'hF);
            if (c == 1) begin
                chk(pin_in[PIN_TXD], port2_transmit_line);
            end
        end
        wr(IDX_IMASK, 8'h01);
        wr(IDX_LOCK, 8'h0D);
        for (int k = 0; k < 2; k++) begin
            ext[PIN_LOCK] <= ~ext[PIN_LOCK];
            tk(3);
            #1;
            chk(edge_event3, 1'h1);
            tk(3);
            rc(IDX_ISTAT, 8'h01);
            chk(irq, 1'h1);
            wr(IDX_ISTAT, 8'h01);
            tk(2);
            chk(irq, 1'h0);
        end
        dd = 8'h00;
        for (int k = 0; k < 2; k++) begin
            wr(IDX_LOCK, 8'h05);
            wr(IDX_LOCK, 8'h09);
            rc(IDX_LOCK, 8'h05);
            chk(device_disable_lock_ctrl, 1'h1);
            ext[PIN_LOCK] <= '1;
            tk(4);
            wr(IDX_DDIS, 8'hA5);
            rc(IDX_DDIS, dd);
            chk(device_disable_value, dd);
            rc(IDX_ISTAT, 8'h02);
            wr(IDX_ISTAT, 8'h02);
            ext[PIN_LOCK] <= '0;
            tk(4);
            dd = 8'h5A ^ 8'(k);
            wr(IDX_DDIS, dd);
            rc(IDX_DDIS, dd);
            chk(device_disable_value, dd);
            if (k == 0) begin
                main_por_rst <= '1;
            end else begin
                hard_rst <= '1;
            end
            @(posedge clk_sys);
            main_por_rst <= '0;
            hard_rst <= '0;
            tk(2);
            rc(IDX_LOCK, 8'h01);
            rc(IDX_TXD, CFG_TXD_RST);
        end
        close_out();
    end
endmodule
`default_nettype wire
